// ===== design/acfg_params.svh
`ifndef ACFG_PARAMS_SVH
`define ACFG_PARAMS_SVH
// ==========================================
// frame geometry, msb first, 24-bit word
`define ACFG_CNT_W 5
`define ACFG_HDR_LAST 5'd15
`define ACFG_FRAME_LAST 5'd23
`define ACFG_RW_BIT 23
`define ACFG_ZERO_HI 22
`define ACFG_ZERO_LO 20
`define ACFG_ADDR_HI 19
`define ACFG_ADDR_LO 8
// ==========================================
// register file
`define ACFG_NREG 17
`define ACFG_REG_RST 8'h00
`define ACFG_LANE_RST 3'h0
`define ACFG_IDX_NONE 5'd31
`define ACFG_OFS_SOFT_RESET 12'h000
`define ACFG_OFS_OUT_IF 12'h007
`define ACFG_OFS_PDN 12'h008
`define ACFG_OFS_OB_OFF_LO 12'h00A
`define ACFG_OFS_OB_OFF_MID 12'h00B
`define ACFG_OFS_OB_OFF_HI 12'h00C
`define ACFG_OFS_PD_MASK 12'h00D
`define ACFG_OFS_SYNC_REF 12'h00E
`define ACFG_OFS_INPUT_AZ 12'h011
`define ACFG_OFS_TRIM 12'h013
`define ACFG_OFS_PAT_LO 12'h014
`define ACFG_OFS_PAT_MID 12'h015
`define ACFG_OFS_PAT_SEL 12'h016
`define ACFG_OFS_DCLK_IN 12'h018
`define ACFG_OFS_FRAME_CLOCK_CTRL 12'h019
`define ACFG_OFS_RES 12'h01B
`define ACFG_OFS_DCLK_DEL 12'h01E
`define ACFG_IDX_SOFT_RESET 5'd0
`define ACFG_IDX_OUT_IF 5'd1
`define ACFG_IDX_PDN 5'd2
`define ACFG_IDX_SYNC_REF 5'd7
`define ACFG_IDX_TRIM 5'd9
// ==========================================
// field positions
`define ACFG_BIT_SOFT_RESET 0
`define ACFG_BIT_TRIM_LOAD 0
`define ACFG_BIT_PD_GLOBAL 0
`define ACFG_BIT_PD_B 1
`define ACFG_BIT_PD_A 2
`define ACFG_BIT_SE_CLK 0
`define ACFG_MAP_HI 7
`define ACFG_MAP_LO 5
// ==========================================
// reference pin comparator codes
`define ACFG_LVL_EXT 2'h3
`define ACFG_LVL_GAINBUF 2'h2
`define ACFG_LVL_INT 2'h1
`define ACFG_LVL_INT_SE 2'h0
`define ACFG_PIN_RST 4'hC
`endif

// ===== design/acfg_pkg.sv
package acfg_pkg;
	// ==========================================
	// serial frame phase
	typedef enum logic [1:0] {
		PH_HEADER,
		PH_WRITE,
		PH_READ
	} acfg_phase_t;
	typedef logic [4:0] acfg_idx_t;
endpackage : acfg_pkg

// ===== design/acfg_port.sv
`timescale 1ns/1ps
`include "acfg_params.svh"

// Functional notes
// - defaults apply without any serial access
// - power-down and reference chosen by pins
// - power-down acts only with sampling clock
// - reset defaults: differential, external, bypass, ddr
// - decode reference pin level into modes
// - shift only while select is low
// - sample data on rising shift edge
// - commit word every 24th rising edge
// - drop partial trailing word at select rise
// - several frames per select low period
// - no minimum rate or duty assumed
// - read flag set: readback, no write
// - read drives eight data bits after address
// - soft reset bit restores defaults, self clears
// - lane mapping applied by trim reload command
module acfg_port (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic SCLK_IN,
	input wire logic SERIAL_SELECT_LOW_IN,
	input wire logic SDIO_IN,
	input wire logic POWERDOWN_SYNC_PIN_IN,
	input wire logic SAMPLE_CLK_PRESENT_IN,
	input wire logic [1:0] REFERENCE_SELECT_PIN_IN,
	output logic SDIO_OUT,
	output logic SDIO_OE_OUT,
	output logic GLOBAL_POWER_DOWN_OUT,
	output logic CHAN_A_POWER_DOWN_OUT,
	output logic CHAN_B_POWER_DOWN_OUT,
	output logic [2:0] OUTPUT_LANE_MAPPING_OUT,
	output logic REF_INTERNAL_OUT,
	output logic REF_GAIN_BUFFER_OUT,
	output logic CLK_SINGLE_ENDED_OUT,
	output logic SERIAL_2WIRE_OUT
);

	// ==========================================
	// address decode
	function automatic acfg_pkg::acfg_idx_t acfg_index(input logic [11:0] addr);
		acfg_pkg::acfg_idx_t idx;
		idx = `ACFG_IDX_NONE;
		unique case (addr)
			`ACFG_OFS_SOFT_RESET: idx = 5'd0;
			`ACFG_OFS_OUT_IF: idx = 5'd1;
			`ACFG_OFS_PDN: idx = 5'd2;
			`ACFG_OFS_OB_OFF_LO: idx = 5'd3;
			`ACFG_OFS_OB_OFF_MID: idx = 5'd4;
			`ACFG_OFS_OB_OFF_HI: idx = 5'd5;
			`ACFG_OFS_PD_MASK: idx = 5'd6;
			`ACFG_OFS_SYNC_REF: idx = 5'd7;
			`ACFG_OFS_INPUT_AZ: idx = 5'd8;
			`ACFG_OFS_TRIM: idx = 5'd9;
			`ACFG_OFS_PAT_LO: idx = 5'd10;
			`ACFG_OFS_PAT_MID: idx = 5'd11;
			`ACFG_OFS_PAT_SEL: idx = 5'd12;
			`ACFG_OFS_DCLK_IN: idx = 5'd13;
			`ACFG_OFS_FRAME_CLOCK_CTRL: idx = 5'd14;
			`ACFG_OFS_RES: idx = 5'd15;
			`ACFG_OFS_DCLK_DEL: idx = 5'd16;
			default: idx = `ACFG_IDX_NONE;
		endcase
		return idx;
	endfunction : acfg_index

	// ==========================================
	// declarations
	logic [7:0] reg_file [0:`ACFG_NREG-1];
	logic [2:0] lane_active;
	logic [`ACFG_CNT_W-1:0] bit_cnt;
	logic [22:0] shift_reg;
	logic [23:0] next_word;
	logic [23:0] word_hold;
	logic commit_tog;
	acfg_pkg::acfg_phase_t phase;
	logic [6:0] rd_left;
	acfg_pkg::acfg_idx_t rd_idx;
	logic [7:0] rd_value;
	wire frame_clr = SERIAL_SELECT_LOW_IN | RST_IN;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic wr_pulse;
	acfg_pkg::acfg_idx_t wr_idx;
	logic [7:0] wr_data;
	logic wr_hit;
	logic soft_rst_hit;
	logic fuse_hit;
	logic [7:0] cur_val;
	logic pd_pin_s;
	logic clk_present_s;
	logic [1:0] ref_lvl_s;

	// ==========================================
	// link side: shift clock domain
	assign next_word = {shift_reg, SDIO_IN};

	// select high holds the frame idle
	always_ff @(posedge SCLK_IN or posedge frame_clr) begin
		if (frame_clr) begin
			bit_cnt <= '0;
		end else if (bit_cnt == `ACFG_FRAME_LAST) begin
			bit_cnt <= '0;
		end else begin
			bit_cnt <= bit_cnt + 5'd1;
		end
	end

	// sample on rising edge, msb first
	always_ff @(posedge SCLK_IN or posedge frame_clr) begin
		if (frame_clr) begin
			shift_reg <= '0;
		end else begin
			shift_reg <= next_word[22:0];
		end
	end

	// held word stays put for a whole frame, so the core may read it late;
	// select must not clear it or a pending toggle would be lost
	// only a full word is handed over
	always_ff @(posedge SCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			word_hold <= '0;
			commit_tog <= 1'b0;
		end else if (bit_cnt == `ACFG_FRAME_LAST) begin
			word_hold <= next_word;
			commit_tog <= ~commit_tog;
		end
	end

	// register file is only changed by earlier frames, so it is quiet here
	assign rd_idx = acfg_index(next_word[11:0]);
	assign rd_value = (rd_idx == `ACFG_IDX_NONE) ? `ACFG_REG_RST : reg_file[rd_idx];

	always_ff @(posedge SCLK_IN or posedge frame_clr) begin
		if (frame_clr) begin
			phase <= acfg_pkg::PH_HEADER;
		end else if (bit_cnt == `ACFG_HDR_LAST) begin
			phase <= next_word[15] ? acfg_pkg::PH_READ : acfg_pkg::PH_WRITE;
		end else if (bit_cnt == `ACFG_FRAME_LAST) begin
			phase <= acfg_pkg::PH_HEADER;
		end
	end

	// data out only in read data phase
	always_ff @(posedge SCLK_IN or posedge frame_clr) begin
		if (frame_clr) begin
			SDIO_OUT <= 1'b0;
			SDIO_OE_OUT <= 1'b0;
			rd_left <= '0;
		end else if (bit_cnt == `ACFG_HDR_LAST) begin
			SDIO_OUT <= next_word[15] & rd_value[7];
			SDIO_OE_OUT <= next_word[15];
			rd_left <= rd_value[6:0];
		end else if (bit_cnt == `ACFG_FRAME_LAST) begin
			SDIO_OUT <= 1'b0;
			SDIO_OE_OUT <= 1'b0;
		end else if (phase == acfg_pkg::PH_READ) begin
			// changes on rising edge, stable for the falling capture
			SDIO_OUT <= rd_left[6];
			rd_left <= {rd_left[5:0], 1'b0};
		end
	end

	// ==========================================
	// crossings into the core clock
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			wr_pulse <= 1'b0;
		end else begin
			tog_s1 <= commit_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			wr_pulse <= tog_s2 ^ tog_s3;
		end
	end

	// async pins; reset to idle pin levels so no false mode follows reset
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pin_s1 <= `ACFG_PIN_RST;
			pin_s2 <= `ACFG_PIN_RST;
		end else begin
			pin_s1 <= {REFERENCE_SELECT_PIN_IN, SAMPLE_CLK_PRESENT_IN, POWERDOWN_SYNC_PIN_IN};
			pin_s2 <= pin_s1;
		end
	end

	assign pd_pin_s = pin_s2[0];
	assign clk_present_s = pin_s2[1];
	assign ref_lvl_s = pin_s2[3:2];

	// ==========================================
	// core register file
	assign wr_idx = acfg_index(word_hold[`ACFG_ADDR_HI:`ACFG_ADDR_LO]);
	assign wr_data = word_hold[7:0];
	assign cur_val = (wr_idx == `ACFG_IDX_NONE) ? `ACFG_REG_RST : reg_file[wr_idx];

	assign wr_hit = wr_pulse && !word_hold[`ACFG_RW_BIT]
		&& (word_hold[`ACFG_ZERO_HI:`ACFG_ZERO_LO] == 3'h0)
		&& (wr_idx != `ACFG_IDX_NONE);
	assign soft_rst_hit = wr_hit && (wr_idx == `ACFG_IDX_SOFT_RESET)
		&& wr_data[`ACFG_BIT_SOFT_RESET];
	assign fuse_hit = wr_hit && (wr_idx == `ACFG_IDX_TRIM) && wr_data[`ACFG_BIT_TRIM_LOAD];

	// all-zero state is the default setup
	// soft reset stores zero, so it self clears
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || soft_rst_hit) begin
			for (int i = 0; i < `ACFG_NREG; i++) begin
				reg_file[i] <= `ACFG_REG_RST;
			end
		end else if (fuse_hit) begin
			// reload wipes earlier writes but the mapping
			for (int i = 0; i < `ACFG_NREG; i++) begin
				if (5'(i) != `ACFG_IDX_OUT_IF) begin
					reg_file[i] <= `ACFG_REG_RST;
				end
			end
		end else if (wr_hit) begin
			reg_file[wr_idx] <= wr_data;
		end
	end

	// mapping field acts only after reload
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || soft_rst_hit) begin
			lane_active <= `ACFG_LANE_RST;
		end else if (fuse_hit) begin
			lane_active <= reg_file[`ACFG_IDX_OUT_IF][`ACFG_MAP_HI:`ACFG_MAP_LO];
		end
	end

	assign OUTPUT_LANE_MAPPING_OUT = lane_active;

	// ==========================================
	// pin controls
	// power-down held while sampling clock absent
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			GLOBAL_POWER_DOWN_OUT <= 1'b0;
			CHAN_A_POWER_DOWN_OUT <= 1'b0;
			CHAN_B_POWER_DOWN_OUT <= 1'b0;
		end else if (clk_present_s) begin
			GLOBAL_POWER_DOWN_OUT <= pd_pin_s | reg_file[`ACFG_IDX_PDN][`ACFG_BIT_PD_GLOBAL];
			CHAN_A_POWER_DOWN_OUT <= reg_file[`ACFG_IDX_PDN][`ACFG_BIT_PD_A];
			CHAN_B_POWER_DOWN_OUT <= reg_file[`ACFG_IDX_PDN][`ACFG_BIT_PD_B];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			REF_INTERNAL_OUT <= 1'b0;
			REF_GAIN_BUFFER_OUT <= 1'b0;
			CLK_SINGLE_ENDED_OUT <= 1'b0;
			SERIAL_2WIRE_OUT <= 1'b0;
		end else begin
			REF_INTERNAL_OUT <= (ref_lvl_s == `ACFG_LVL_INT) || (ref_lvl_s == `ACFG_LVL_INT_SE);
			REF_GAIN_BUFFER_OUT <= (ref_lvl_s == `ACFG_LVL_GAINBUF);
			CLK_SINGLE_ENDED_OUT <= (ref_lvl_s == `ACFG_LVL_INT_SE)
				| reg_file[`ACFG_IDX_SYNC_REF][`ACFG_BIT_SE_CLK];
			SERIAL_2WIRE_OUT <= (ref_lvl_s == `ACFG_LVL_INT_SE);
		end
	end

	// ==========================================
	// assertions, link domain
	property p_read_drive;
		@(posedge SCLK_IN) disable iff (frame_clr)
		(bit_cnt == `ACFG_HDR_LAST && shift_reg[14]) |=> SDIO_OE_OUT [*8] ##1 !SDIO_OE_OUT;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("readback drive window wrong");
	property p_write_quiet;
		@(posedge SCLK_IN) disable iff (frame_clr)
		(bit_cnt == `ACFG_HDR_LAST && !shift_reg[14]) |=> !SDIO_OE_OUT [*8];
	endproperty
	a_write_quiet: assert property (p_write_quiet) else $error("data line driven in write");
	property p_header_quiet;
		@(posedge SCLK_IN) disable iff (frame_clr)
		(bit_cnt < `ACFG_HDR_LAST) |=> !SDIO_OE_OUT;
	endproperty
	a_header_quiet: assert property (p_header_quiet) else $error("data line driven in header");
	property p_commit_24;
		@(posedge SCLK_IN) disable iff (frame_clr)
		(bit_cnt == `ACFG_FRAME_LAST) |=> (commit_tog != $past(commit_tog)) && (bit_cnt == 5'd0);
	endproperty
	a_commit_24: assert property (p_commit_24) else $error("no commit at 24th edge");
	property p_no_partial;
		@(posedge SCLK_IN) disable iff (frame_clr)
		(bit_cnt != `ACFG_FRAME_LAST) |=> $stable(commit_tog);
	endproperty
	a_no_partial: assert property (p_no_partial) else $error("commit before full word");
	property p_msb_first;
		@(posedge SCLK_IN) disable iff (frame_clr)
		(bit_cnt == `ACFG_FRAME_LAST) |=> word_hold[23] == $past(shift_reg[22]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("word not msb first");

	// ==========================================
	// assertions, core domain
	property p_defaults;
		@(posedge CLK_IN)
		RST_IN |=> (reg_file[`ACFG_IDX_PDN] == `ACFG_REG_RST)
			&& (OUTPUT_LANE_MAPPING_OUT == `ACFG_LANE_RST);
	endproperty
	a_defaults: assert property (p_defaults) else $error("reset defaults not restored");
	property p_soft_reset;
		@(posedge CLK_IN) disable iff (RST_IN)
		soft_rst_hit |=> (reg_file[`ACFG_IDX_SOFT_RESET] == `ACFG_REG_RST)
			&& (reg_file[`ACFG_IDX_PDN] == `ACFG_REG_RST);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
	property p_write_lands;
		@(posedge CLK_IN) disable iff (RST_IN)
		(wr_hit && !soft_rst_hit && !fuse_hit) |=> reg_file[$past(wr_idx)] == $past(wr_data);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write did not land");
	property p_read_no_write;
		@(posedge CLK_IN) disable iff (RST_IN)
		(wr_pulse && word_hold[`ACFG_RW_BIT]) |=> cur_val == $past(cur_val);
	endproperty
	a_read_no_write: assert property (p_read_no_write) else $error("read frame wrote");
	property p_one_pulse;
		@(posedge CLK_IN) disable iff (RST_IN)
		wr_pulse |=> !wr_pulse;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("frame handled twice");
	property p_pd_hold;
		@(posedge CLK_IN) disable iff (RST_IN)
		!clk_present_s |=> $stable(GLOBAL_POWER_DOWN_OUT);
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("power-down moved without clock");
	property p_pd_pin;
		@(posedge CLK_IN) disable iff (RST_IN)
		(clk_present_s && pd_pin_s) |=> GLOBAL_POWER_DOWN_OUT;
	endproperty
	a_pd_pin: assert property (p_pd_pin) else $error("pin power-down ignored");
	property p_ref_low;
		@(posedge CLK_IN) disable iff (RST_IN)
		(ref_lvl_s == `ACFG_LVL_INT_SE) |=> REF_INTERNAL_OUT && CLK_SINGLE_ENDED_OUT
			&& SERIAL_2WIRE_OUT && !REF_GAIN_BUFFER_OUT;
	endproperty
	a_ref_low: assert property (p_ref_low) else $error("low reference level decode");
	property p_ref_high;
		@(posedge CLK_IN) disable iff (RST_IN)
		(ref_lvl_s == `ACFG_LVL_EXT) |=> !REF_INTERNAL_OUT && !SERIAL_2WIRE_OUT;
	endproperty
	a_ref_high: assert property (p_ref_high) else $error("high reference level decode");
	property p_lane_map;
		@(posedge CLK_IN) disable iff (RST_IN)
		(fuse_hit && !soft_rst_hit) |=> OUTPUT_LANE_MAPPING_OUT
			== $past(reg_file[`ACFG_IDX_OUT_IF][`ACFG_MAP_HI:`ACFG_MAP_LO]);
	endproperty
	a_lane_map: assert property (p_lane_map) else $error("mapping not applied");

	// ==========================================
	// coverage
	property p_cov_read;
		@(posedge SCLK_IN) disable iff (frame_clr)
		SDIO_OE_OUT ##1 !SDIO_OE_OUT;
	endproperty
	c_cov_read: cover property (p_cov_read);
	property p_cov_write;
		@(posedge CLK_IN) disable iff (RST_IN)
		wr_hit && !soft_rst_hit;
	endproperty
	c_cov_write: cover property (p_cov_write);
	property p_cov_soft;
		@(posedge CLK_IN) disable iff (RST_IN)
		soft_rst_hit;
	endproperty
	c_cov_soft: cover property (p_cov_soft);
	property p_cov_fuse;
		@(posedge CLK_IN) disable iff (RST_IN)
		fuse_hit;
	endproperty
	c_cov_fuse: cover property (p_cov_fuse);

endmodule : acfg_port

// ===== testbench/acfg_host.sv
`timescale 1ns/1ps
// ==========================================
// host controller model, shift clock runs inside frames and, from idle_clk, with select high
module acfg_host (
	input wire logic sdio_wire_in,
	output logic sclk_out,
	output logic sel_low_out,
	output logic sdio_out
);
	logic in_rd;
	initial begin
		sclk_out = 1'b0;
		sel_low_out = 1'b1;
		sdio_out = 1'b0;
		in_rd = 1'b0;
	end
	task automatic sel(input logic lvl);
		#21;
		sel_low_out = lvl;
		#20;
	endtask : sel
	// clocks with select high, data toggling
	task automatic idle_clk(input int n);
		for (int i = 0; i < n; i++) begin
			sdio_out = ~sdio_out;
			#7.5 sclk_out = 1'b1;
			#7.5 sclk_out = 1'b0;
		end
	endtask : idle_clk
	// msb first frames, flag set means readback
	task automatic xfer(input logic [23:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		for (int i = 0; i < n; i++) begin
			if (w[23] && i >= 15) begin
				in_rd = 1'b1;
			end
			if (w[23] && i >= 16) begin
				// released line toggles so a stale level cannot pass
				sdio_out = ~sdio_out;
			end else begin
				sdio_out = w[23 - i];
			end
			#7.5 sclk_out = 1'b1;
			// one long high phase per frame, uneven duty
			if (i == 11) #100;
			#7.5;
			if (w[23] && i >= 15 && i <= 22) rd[22 - i] = sdio_wire_in;
			sclk_out = 1'b0;
		end
		in_rd = 1'b0;
	endtask : xfer
endmodule : acfg_host

// ===== testbench/acfg_port_tb_top.sv
`timescale 1ns/1ps
module acfg_port_tb_top;
	logic clk;
	logic rst;
	logic pdn_pin;
	logic smp_clk;
	logic [1:0] ref_code;
	logic sclk, sel_low, host_sdio, sdio_o, sdio_oe, gpd, apd, bpd;
	logic ref_int, ref_gb, clk_se, ser2;
	logic [2:0] lane;
	logic [7:0] v;
	wire logic sdio_wire;
	assign sdio_wire = sdio_oe ? sdio_o : host_sdio;
	int fails = 0;
	int tests_run = 0;
	logic [11:0] offs [17] = '{12'h000, 12'h007, 12'h008, 12'h00A, 12'h00B, 12'h00C,
		12'h00D, 12'h00E, 12'h011, 12'h013, 12'h014, 12'h015, 12'h016, 12'h018,
		12'h019, 12'h01B, 12'h01E};
	always #2.5 clk = ~clk;
	acfg_host host_u (.sdio_wire_in(sdio_wire), .sclk_out(sclk), .sel_low_out(sel_low),
		.sdio_out(host_sdio));
	acfg_port dut_u (.CLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk),
		.SERIAL_SELECT_LOW_IN(sel_low), .SDIO_IN(sdio_wire), .POWERDOWN_SYNC_PIN_IN(pdn_pin),
		.SAMPLE_CLK_PRESENT_IN(smp_clk), .REFERENCE_SELECT_PIN_IN(ref_code),
		.SDIO_OUT(sdio_o), .SDIO_OE_OUT(sdio_oe), .GLOBAL_POWER_DOWN_OUT(gpd),
		.CHAN_A_POWER_DOWN_OUT(apd), .CHAN_B_POWER_DOWN_OUT(bpd),
		.OUTPUT_LANE_MAPPING_OUT(lane), .REF_INTERNAL_OUT(ref_int),
		.REF_GAIN_BUFFER_OUT(ref_gb), .CLK_SINGLE_ENDED_OUT(clk_se), .SERIAL_2WIRE_OUT(ser2));
	// ==========================================
	// helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	function automatic logic [7:0] pat(input int i);
		return {i[3:0], ~i[3:0]};
	endfunction : pat
	// commit lands 4-5 core edges after the last shift edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		host_u.sel(1'b0);
		host_u.xfer({1'b0, 3'h0, a, d}, 24, v);
		host_u.sel(1'b1);
		cyc(6);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
		host_u.sel(1'b0);
		host_u.xfer({1'b1, 3'h0, a, 8'h00}, 24, v);
		host_u.sel(1'b1);
		check("readback", v, exp);
	endtask : rdc
	task automatic finish_test;
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	// line driven only in readback phase
	always @(negedge clk) begin
		if (!rst && !host_u.in_rd && sdio_oe !== 1'b0) check("oe", {7'h00, sdio_oe}, 8'h00);
	end
	// ==========================================
	// scenarios
	task automatic t_defaults;
		check("outs", {1'b0, gpd, apd, bpd, ref_int, ref_gb, clk_se, ser2}, 8'h00);
		check("lane", {5'h00, lane}, 8'h00);
		for (int i = 0; i < 17; i++) rdc(offs[i], 8'h00);
	endtask : t_defaults
	task automatic t_ref;
		logic [3:0] exp [4] = '{4'b1011, 4'b1000, 4'b0100, 4'b0000};
		for (int c = 0; c < 4; c++) begin
			ref_code = c[1:0];
			cyc(5);
			check("ref", {4'h0, ref_int, ref_gb, clk_se, ser2}, {4'h0, exp[c]});
		end
		ref_code = 2'h3;
		cyc(5);
	endtask : t_ref
	task automatic t_regs;
		for (int i = 1; i < 17; i++) begin
			if (i != 9) wr(offs[i], pat(i));
		end
		for (int i = 1; i < 17; i++) begin
			if (i != 9) rdc(offs[i], pat(i));
		end
	endtask : t_regs
	task automatic t_multi;
		host_u.sel(1'b0);
		host_u.xfer({1'b0, 3'h0, 12'h014, 8'h3C}, 24, v);
		host_u.xfer({1'b0, 3'h0, 12'h015, 8'hC3}, 24, v);
		host_u.xfer({1'b1, 3'h0, 12'h014, 8'h00}, 24, v);
		check("multi", v, 8'h3C);
		host_u.xfer({1'b0, 3'h0, 12'h016, 8'hFF}, 20, v);
		host_u.sel(1'b1);
		cyc(6);
		rdc(12'h015, 8'hC3);
		rdc(12'h016, pat(12));
		rdc(12'h014, 8'h3C);
	endtask : t_multi
	task automatic t_ignore;
		host_u.idle_clk(30);
		rdc(12'h014, 8'h3C);
	endtask : t_ignore
	task automatic t_pdn;
		wr(12'h008, 8'h00);
		smp_clk = 1'b0;
		pdn_pin = 1'b1;
		cyc(8);
		check("pdn", {7'h00, gpd}, 8'h00);
		smp_clk = 1'b1;
		cyc(8);
		check("pdn", {7'h00, gpd}, 8'h01);
		pdn_pin = 1'b0;
		cyc(8);
		wr(12'h008, 8'h06);
		check("pdn", {5'h00, gpd, apd, bpd}, 8'h03);
		smp_clk = 1'b0;
		wr(12'h008, 8'h01);
		cyc(8);
		check("pdn", {5'h00, gpd, apd, bpd}, 8'h03);
		smp_clk = 1'b1;
		cyc(8);
		check("pdn", {5'h00, gpd, apd, bpd}, 8'h04);
		wr(12'h008, 8'h00);
	endtask : t_pdn
	task automatic t_trim;
		wr(12'h007, 8'hA0);
		wr(12'h014, 8'h11);
		wr(12'h013, 8'h01);
		check("lane", {5'h00, lane}, 8'h05);
		rdc(12'h014, 8'h00);
		rdc(12'h007, 8'hA0);
	endtask : t_trim
	task automatic t_soft;
		wr(12'h00E, 8'h01);
		check("se_clk", {7'h00, clk_se}, 8'h01);
		wr(12'h000, 8'h01);
		check("lane", {5'h00, lane}, 8'h00);
		check("se_clk", {7'h00, clk_se}, 8'h00);
		for (int i = 0; i < 17; i++) rdc(offs[i], 8'h00);
	endtask : t_soft
	// ==========================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		pdn_pin = 1'b0;
		smp_clk = 1'b1;
		ref_code = 2'h3;
		cyc(5);
		rst = 1'b0;
		cyc(2);
		t_defaults();
		t_ref();
		t_regs();
		t_multi();
		t_ignore();
		t_pdn();
		t_trim();
		t_soft();
		finish_test();
	end
	// about 83 frames of 0.55 us each, so 200 us is ample
	initial begin
		#200000;
		fails++;
		finish_test();
	end
endmodule : acfg_port_tb_top
